/* File: verilog/sbs_pkg.sv */
// How it works
// RULE1 - Top field bit set: one source bit (5:3) lands at destination bit (2:0)
// RULE2 - Field 6:5 = 01: source pair 4:3 moves to destination pair 1:0
// RULE3 - Field 6:4 = 001: source nibble bit 3 moves to destination nibble bit 0
// RULE4 - Field 6:4 = 000: whole byte stored unchanged, low bits ignored
// RULE5 - Outbound connections always send a complete eight-bit byte
// RULE6 - Several inbound pieces naming one location merge into that byte
// RULE7 - Outbound reads and sends the whole stored byte unchanged
// RULE8 - Outbound subrate field has no effect on what is sent
// RULE9 - Software never programs two di-bit extractions from one incoming slot
// RULE10 - Splitting a byte needs rebroadcast onto extra channels by the application
// RULE11 - Reserved field bits are don't-care; either value behaves the same
// RULE12 - Rearrangement happens only while mode register bit 7 is set
// RULE13 - Double-buffered: page select bit of inbound subrate entry picks data page
// RULE14 - Inbound piece writes only its destination bits; other bits are kept
package sbs_pkg;

  // Data memory and input queue geometry
  localparam int SBS_DM_AW      = 12;
  localparam int SBS_FIFO_DEPTH = 4;
  localparam int SBS_PAGE_BIT   = 11;

  // Register bus map; printed offsets are word indices
  localparam int              SBS_BUS_AW      = 12;
  localparam logic [11:0]     SBS_MODE_IDX    = 12'h105;
  localparam logic [11:0]     SBS_STAT_IDX    = 12'h106;
  localparam logic [11:0]     SBS_MODE_ADDR   = 12'(SBS_MODE_IDX * 4);
  localparam logic [11:0]     SBS_STAT_ADDR   = 12'(SBS_STAT_IDX * 4);
  localparam logic [7:0]      SBS_MODE_RST    = 8'h00;
  localparam int              SBS_MODE_SUBEN  = 7;
  localparam int              SBS_MODE_DBUF   = 0;
  localparam int              SBS_STAT_PAGE   = 0;
  localparam int              SBS_STAT_PEND   = 1;
  localparam int              SBS_STAT_BUSY   = 2;

  // Subrate field codes
  localparam int              SBS_BIT_FLAG    = 6;
  localparam logic [1:0]      SBS_DIBIT_CODE  = 2'b01;
  localparam logic [2:0]      SBS_NIB_CODE    = 3'b001;
  localparam logic [2:0]      SBS_BYTE_CODE   = 3'b000;

  // One half connection with its serial byte
  typedef struct packed {
    logic        outbound;
    logic        page_select_bit;
    logic [6:0]  sub;
    logic [11:0] tag;
    logic [7:0]  data;
  } sbs_req_s;

  // Bits to touch and the value to place there
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] val;
  } sbs_piece_s;

  typedef enum logic [1:0] {SBS_IDLE, SBS_MERGE, SBS_SEND} sbs_state_e;

endpackage

/* File: verilog/sbs_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sbs_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rstn,
  // Fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0] store [D];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0]   cnt;
  logic [AW:0]   next_cnt;
  logic          push;
  logic          pop;

  // Handshakes on both sides
  assign push       = i_in_valid && o_in_ready;
  assign pop        = o_out_valid && i_out_ready;
  assign o_out_data = store[rptr];

  always_comb begin
    next_cnt = cnt;
    if (push && !pop) next_cnt = cnt + 1'b1;
    if (pop && !push) next_cnt = cnt - 1'b1;
  end

  // Storage has no reset; only pointers matter
  always_ff @(posedge i_mclk) begin
    if (push) store[wptr] <= i_in_data;
  end

  // Pointers wrap at depth, not at a power of two
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) wptr <= (wptr == AW'(D - 1)) ? '0 : wptr + 1'b1;
      if (pop) rptr <= (rptr == AW'(D - 1)) ? '0 : rptr + 1'b1;
    end
  end

  // Flags registered so ready and valid leave straight from flops
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt         <= '0;
      o_in_ready  <= 1'b0;
      o_out_valid <= 1'b0;
    end else begin
      cnt         <= next_cnt;
      o_in_ready  <= (next_cnt < (AW + 1)'(D));
      o_out_valid <= (next_cnt != '0);
    end
  end
endmodule
`default_nettype wire

/* File: verilog/sbs_dmem.sv */
`timescale 1ns/1ps
`default_nettype none
module sbs_dmem
  import sbs_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_rstn,
  // Single port
  input  wire logic                 i_we,
  input  wire logic [SBS_DM_AW-1:0] i_addr,
  input  wire logic [7:0]           i_wdata,
  output logic [7:0]                o_rdata
);
  logic [7:0] mem [2**SBS_DM_AW];

  // Array write, no reset on storage
  always_ff @(posedge i_mclk) begin
    if (i_we) mem[i_addr] <= i_wdata;
  end

  // Registered read, old contents on a same-cycle write
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) o_rdata <= 8'h00;
    else o_rdata <= mem[i_addr];
  end
endmodule
`default_nettype wire

/* File: verilog/sbs_subrate_shuffle.sv */
`timescale 1ns/1ps
`default_nettype none
module sbs_subrate_shuffle
  import sbs_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_rstn,
  // Avalon-MM slave
  input  wire logic [SBS_BUS_AW-1:0] i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic [31:0]                o_avs_readdata,
  output logic                       o_avs_waitrequest,
  // Half connections from the switch
  input  wire logic                  i_conn_valid,
  input  wire sbs_req_s              i_conn,
  output logic                       o_conn_ready,
  // Frame timing
  input  wire logic                  i_frame_tick,
  // Outbound byte
  output logic                       o_out_valid,
  output logic [7:0]                 o_out_byte,
  output logic [11:0]                o_out_tag
);
  sbs_state_e          state;
  sbs_req_s            f_req;
  sbs_req_s            cur_req;
  sbs_piece_s          cur_piece;
  sbs_piece_s          f_piece;
  logic                f_valid;
  logic                f_take;
  logic                f_sub;
  logic [7:0]          mode;
  logic                active_page;
  logic                mem_we;
  logic [SBS_DM_AW-1:0] mem_addr;
  logic [SBS_DM_AW-1:0] f_addr;
  logic [SBS_DM_AW-1:0] cur_addr;
  logic [7:0]          mem_wdata;
  logic [7:0]          mem_rdata;
  logic                sub_en;
  logic                dbuf;

  assign sub_en = mode[SBS_MODE_SUBEN];
  assign dbuf   = mode[SBS_MODE_DBUF];

  // Mask and placed value for one incoming byte
  function automatic sbs_piece_s piece_of(input logic [6:0] f, input logic [7:0] d,
                                          input logic en);
    sbs_piece_s p;
    p.mask = 8'hFF;
    p.val  = d;
    if (en && f[SBS_BIT_FLAG]) begin
      p.mask = 8'h01 << f[2:0]; // [RULE1]
      p.val  = {7'h00, d[f[5:3]]} << f[2:0]; // [RULE1]
    end else if (en && f[6:5] == SBS_DIBIT_CODE) begin
      // Bit 2 never read, so its value cannot matter
      p.mask = 8'h03 << {f[1:0], 1'b0}; // [RULE2] [RULE11]
      p.val  = {6'h00, 2'(d >> {f[4:3], 1'b0})} << {f[1:0], 1'b0}; // [RULE2]
    end else if (en && f[6:4] == SBS_NIB_CODE) begin
      // Bits 2:1 never read
      p.mask = f[0] ? 8'hF0 : 8'h0F; // [RULE3] [RULE11]
      p.val  = f[3] ? {d[7:4], d[7:4]} : {d[3:0], d[3:0]}; // [RULE3]
    end
    return p;
  endfunction

  // Head of the input queue
  assign f_take  = f_valid && (state == SBS_IDLE);
  assign f_sub   = sub_en && (f_req.sub[6:4] != SBS_BYTE_CODE); // [RULE4] [RULE12]
  assign f_piece = piece_of(f_req.sub, f_req.data, sub_en); // [RULE12]

  // Page choice: only subrate inbound and outbound honour the page bit
  always_comb begin
    f_addr = f_req.tag;
    if (dbuf) begin
      if (f_req.outbound || f_sub) begin
        f_addr[SBS_PAGE_BIT] = f_req.page_select_bit ^ active_page; // [RULE13]
      end else begin
        f_addr[SBS_PAGE_BIT] = active_page;
      end
    end
  end

  sbs_fifo #(
    .W ($bits(sbs_req_s)),
    .D (SBS_FIFO_DEPTH)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_rstn      (i_rstn),
    .i_in_valid  (i_conn_valid),
    .i_in_data   (i_conn),
    .o_in_ready  (o_conn_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_req),
    .i_out_ready (state == SBS_IDLE)
  );

  sbs_dmem u_dmem (
    .i_mclk  (i_mclk),
    .i_rstn  (i_rstn),
    .i_we    (mem_we),
    .i_addr  (mem_addr),
    .i_wdata (mem_wdata),
    .o_rdata (mem_rdata)
  );

  // Memory port steering per state
  always_comb begin
    mem_we    = 1'b0;
    mem_addr  = f_addr;
    mem_wdata = f_req.data;
    case (state)
      SBS_IDLE: begin
        // Plain byte written at once; pieces and outbound read first
        if (f_take && !f_req.outbound && !f_sub) mem_we = 1'b1; // [RULE4]
      end
      SBS_MERGE: begin
        mem_addr  = cur_addr; // [RULE6]
        mem_we    = 1'b1;
        mem_wdata = (mem_rdata & ~cur_piece.mask)
                  | (cur_piece.val & cur_piece.mask); // [RULE14] [RULE6]
      end
      SBS_SEND: begin
        mem_addr = cur_addr;
      end
      default: begin
        mem_addr = f_addr;
      end
    endcase
  end

  // Sequencer: one entry at a time, so a write lands before the next read
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= SBS_IDLE;
    end else begin
      case (state)
        SBS_IDLE: begin
          if (f_take && f_req.outbound) state <= SBS_SEND;
          else if (f_take && f_sub) state <= SBS_MERGE;
        end
        SBS_MERGE: state <= SBS_IDLE;
        SBS_SEND: state <= SBS_IDLE;
        default: state <= SBS_IDLE;
      endcase
    end
  end

  // Entry held for the second step
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cur_req   <= '0;
      cur_addr  <= '0;
      cur_piece <= '0;
    end else if (f_take) begin
      cur_req   <= f_req;
      cur_addr  <= f_addr;
      cur_piece <= f_piece;
    end
  end

  // Outbound byte: whole stored byte, subrate field never looked at
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_out_valid <= 1'b0;
      o_out_byte  <= 8'h00;
      o_out_tag   <= 12'h000;
    end else begin
      o_out_valid <= (state == SBS_SEND); // [RULE5]
      if (state == SBS_SEND) begin
        o_out_byte <= mem_rdata; // [RULE7] [RULE8]
        o_out_tag  <= cur_req.tag;
      end
    end
  end

  // Active page flips each frame while double buffered
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) active_page <= 1'b0;
    else if (!dbuf) active_page <= 1'b0;
    else if (i_frame_tick) active_page <= !active_page;
  end

  // Bus answer one cycle after the request appears
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) o_avs_waitrequest <= 1'b1;
    else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) o_avs_waitrequest <= 1'b0;
    else o_avs_waitrequest <= 1'b1;
  end

  // Mode register write on the accepting edge, lane 0 only
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode <= SBS_MODE_RST;
    end else if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
                 && i_avs_address == SBS_MODE_ADDR) begin
      mode <= i_avs_writedata[7:0];
    end
  end

  // Read data ready with the falling waitrequest; unmapped reads zero
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && o_avs_waitrequest) begin
      o_avs_readdata <= 32'h0000_0000;
      if (i_avs_address == SBS_MODE_ADDR) begin
        o_avs_readdata[7:0] <= mode;
      end else if (i_avs_address == SBS_STAT_ADDR) begin
        o_avs_readdata[SBS_STAT_PAGE] <= active_page;
        o_avs_readdata[SBS_STAT_PEND] <= f_valid;
        o_avs_readdata[SBS_STAT_BUSY] <= (state != SBS_IDLE);
      end
    end
  end

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  sequence piece_pop;
    f_take && !f_req.outbound && f_sub;
  endsequence
  sequence out_pop;
    f_take && f_req.outbound;
  endsequence

  bit_move_a: assert property ( // [RULE1]
    (state == SBS_MERGE && cur_req.sub[SBS_BIT_FLAG])
    |-> mem_wdata[cur_req.sub[2:0]] == cur_req.data[cur_req.sub[5:3]])
    else $error("bit piece misplaced");
  dibit_move_a: assert property ( // [RULE2]
    (state == SBS_MERGE && cur_req.sub[6:5] == SBS_DIBIT_CODE)
    |-> mem_wdata[{cur_req.sub[1:0], 1'b0} +: 2] == cur_req.data[{cur_req.sub[4:3], 1'b0} +: 2])
    else $error("di-bit piece misplaced");
  nibble_move_a: assert property ( // [RULE3]
    (state == SBS_MERGE && cur_req.sub[6:4] == SBS_NIB_CODE)
    |-> mem_wdata[{cur_req.sub[0], 2'b00} +: 4] == cur_req.data[{cur_req.sub[3], 2'b00} +: 4])
    else $error("nibble piece misplaced");
  byte_write_a: assert property ( // [RULE4]
    (f_take && !f_req.outbound && !f_sub) |-> mem_we && mem_wdata == f_req.data
    ##1 state == SBS_IDLE)
    else $error("plain byte not stored whole");
  enable_gate_a: assert property ( // [RULE12]
    (f_take && !f_req.outbound && !sub_en) |-> mem_we && mem_wdata == f_req.data)
    else $error("rearranged while disabled");
  keep_bits_a: assert property ( // [RULE14]
    piece_pop |=> mem_we && ((mem_wdata ^ mem_rdata) & ~cur_piece.mask) == 8'h00)
    else $error("bits outside piece changed");
  shared_loc_a: assert property ( // [RULE6]
    piece_pop |=> mem_addr == $past(mem_addr))
    else $error("merge went to another location");
  whole_out_a: assert property ( // [RULE7]
    out_pop |-> !mem_we ##1 !mem_we ##1 o_out_valid && o_out_byte == $past(mem_rdata))
    else $error("outbound byte not sent whole");
  out_tag_a: assert property ( // [RULE5]
    out_pop |-> ##2 o_out_valid && o_out_tag == $past(f_req.tag, 2))
    else $error("outbound byte missing");
  sub_ignored_a: assert property ( // [RULE8]
    out_pop |-> mem_addr[10:0] == f_req.tag[10:0])
    else $error("outbound address altered");
  reserved_bit_a: assert property ( // [RULE11]
    f_take |-> piece_of(f_req.sub ^ 7'h04, f_req.data, sub_en) == f_piece
               || f_req.sub[SBS_BIT_FLAG])
    else $error("reserved bit changed result");
  page_pick_a: assert property ( // [RULE13]
    (piece_pop and (dbuf)) |-> mem_addr[SBS_PAGE_BIT] == (f_req.page_select_bit ^ active_page))
    else $error("wrong data page");

  // Bus side: one wait state, then exactly one answer cycle
  sequence bus_ask;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence bus_done;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence

  bus_answer_a: assert property (
    bus_ask |=> bus_done)
    else $error("bus answer not one cycle");
  wait_idle_a: assert property (
    !(i_avs_read || i_avs_write) && o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("bus answered without a request");
  mode_keep_a: assert property ( // [RULE12]
    !(i_avs_write && !o_avs_waitrequest) |=> $stable(mode))
    else $error("mode changed without a write");
  mode_read_a: assert property ( // [RULE12]
    (i_avs_read && o_avs_waitrequest && i_avs_address == SBS_MODE_ADDR)
    |=> o_avs_readdata == {24'h000000, $past(mode)})
    else $error("mode read wrong");
  stat_read_a: assert property ( // [RULE13]
    (i_avs_read && o_avs_waitrequest && i_avs_address == SBS_STAT_ADDR)
    |=> o_avs_readdata[SBS_STAT_PAGE] == $past(active_page)
        && o_avs_readdata[31:3] == 29'h0)
    else $error("status read wrong");

  // Outbound byte: one pulse per send, held in between
  out_single_a: assert property ( // [RULE5]
    o_out_valid |=> !o_out_valid)
    else $error("outbound byte sent twice");
  byte_hold_a: assert property ( // [RULE7]
    !o_out_valid |-> $stable(o_out_byte) && $stable(o_out_tag))
    else $error("outbound byte moved between sends");

  // Piece merge: read step, one write step, then back to idle
  sequence merge_step;
    state == SBS_MERGE && mem_we && mem_addr == cur_addr;
  endsequence
  sequence back_idle;
    state == SBS_IDLE;
  endsequence

  merge_order_a: assert property ( // [RULE6] [RULE14]
    piece_pop |=> merge_step ##1 back_idle)
    else $error("piece merge out of step");

  // Plain bytes ignore the page bit; the page flips on a frame tick and rests at 0 while single buffered
  plain_page_a: assert property ( // [RULE13]
    (f_take && !f_req.outbound && !f_sub && dbuf)
    |-> mem_we && mem_addr[SBS_PAGE_BIT] == active_page)
    else $error("plain byte missed the active page");
  page_rest_a: assert property ( // [RULE13]
    !dbuf |=> !active_page)
    else $error("page moved while single buffered");
  page_flip_a: assert property ( // [RULE13]
    (dbuf && i_frame_tick) |=> active_page != $past(active_page))
    else $error("page did not flip at frame tick");

  // Reserved positions of nibble and byte fields
  nib_reserved_a: assert property ( // [RULE11]
    (f_take && f_req.sub[6:4] == SBS_NIB_CODE)
    |-> piece_of(f_req.sub ^ 7'h02, f_req.data, sub_en) == f_piece)
    else $error("nibble reserved bit changed result");
  byte_reserved_a: assert property ( // [RULE11]
    (f_take && f_req.sub[6:4] == SBS_BYTE_CODE)
    |-> piece_of(f_req.sub ^ 7'h0F, f_req.data, sub_en) == f_piece && !f_sub)
    else $error("byte reserved bits changed result");
endmodule
`default_nettype wire

/* File: dv/sbs_conn_src.sv */
`timescale 1ns/1ps
`default_nettype none
module sbs_conn_src
  import sbs_pkg::*;
(
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  // Pacing
  input  wire logic i_slow,
  // Half connections
  output var logic  o_conn_valid,
  output var sbs_req_s o_conn,
  input  wire logic i_conn_ready
);
  sbs_req_s q[$];
  logic     take;
  // Each entry carries one piece of one slot
  function automatic bit idle();
    return q.size() == 0 && !o_conn_valid;
  endfunction
  // Held until accepted; idle lines toggle so stale data never looks valid
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_conn_valid <= 1'b0;
      o_conn <= '0;
    end else begin
      take = o_conn_valid && i_conn_ready;
      if (take) void'(q.pop_front());
      if (!o_conn_valid || take) begin
        if (q.size() > 0 && (!i_slow || $urandom_range(3) == 0)) begin
          o_conn_valid <= 1'b1;
          o_conn <= q[0];
        end else begin
          o_conn_valid <= 1'b0;
          o_conn <= ~o_conn;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/test_sbs_subrate_shuffle.sv */
`timescale 1ns/1ps
`default_nettype none
module test_sbs_subrate_shuffle;
  import sbs_pkg::*;
  logic        i_mclk, i_rstn, rd_s, wr_s, tick_s, slow, cv, cr, ov, wreq, act;
  logic [11:0] addr, otag;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  be;
  logic [7:0]  obyte, mode, bcast;
  logic [7:0]  mem [4096];
  sbs_req_s    conn;
  logic [19:0] exp_q[$];
  int          mismatches, comparisons, refusals, k;

  // Free-running clock
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  sbs_subrate_shuffle sbs_subrate_shuffle_inst (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_avs_address(addr), .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_conn_valid(cv), .i_conn(conn), .o_conn_ready(cr), .i_frame_tick(tick_s),
    .o_out_valid(ov), .o_out_byte(obyte), .o_out_tag(otag));
  sbs_conn_src sbs_conn_src_inst (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_slow(slow),
    .o_conn_valid(cv), .o_conn(conn), .i_conn_ready(cr));

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic expired();
    compare(32'h0, 32'h1);
    print_verdict();
  endtask

  // Outbound bytes checked against the model in order; refusals counted
  always @(posedge i_mclk) begin
    if (cv === 1'b1 && cr === 1'b0) refusals++;
    if (ov === 1'b1) begin
      if (exp_q.size() == 0) compare({12'h000, otag, obyte}, 32'hFFFFFFFF);
      else compare({12'h000, otag, obyte}, {12'h0, exp_q.pop_front()});
    end
  end

  // One Avalon access; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int n;
    @(posedge i_mclk);
    wr_s <= w;
    rd_s <= !w;
    addr <= a;
    wdata <= d;
    be <= b;
    for (n = 0; n < 50; n++) begin
      @(posedge i_mclk);
      if (wreq === 1'b0) break;
    end
    if (n == 50) expired();
    rd = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask

  // Expected stored byte after one inbound entry
  function automatic logic [7:0] merge(input logic [7:0] o, input logic [6:0] s,
                                       input logic [7:0] d);
    logic [7:0] n;
    n = o;
    if (!mode[SBS_MODE_SUBEN] || s[6:4] == SBS_BYTE_CODE) n = d;
    else if (s[SBS_BIT_FLAG]) n[s[2:0]] = d[s[5:3]];
    else if (s[6:5] == SBS_DIBIT_CODE) n[2*s[1:0] +: 2] = d[2*s[4:3] +: 2];
    else n[4*s[0] +: 4] = d[4*s[3] +: 4];
    return n;
  endfunction

  // Reserved bits random, so either value must act alike
  function automatic logic [6:0] rsub(input int t);
    logic [6:0] r;
    r = 7'($urandom);
    case (t)
      0: r[6:4] = SBS_BYTE_CODE;
      1: r[6] = 1'b1;
      2: r[6:5] = SBS_DIBIT_CODE;
      default: r[6:4] = SBS_NIB_CODE;
    endcase
    return r;
  endfunction

  task automatic send(input logic ob, input logic ps, input logic [6:0] s,
                      input logic [11:0] t, input logic [7:0] d);
    logic [11:0] a;
    logic        pg;
    // Plain inbound bytes always land on the active page
    pg = (ob || (mode[SBS_MODE_SUBEN] && s[6:4] != SBS_BYTE_CODE)) ? ps ^ act : act;
    a = mode[SBS_MODE_DBUF] ? {pg, t[10:0]} : t;
    if (ob) exp_q.push_back({t, mem[a]});
    else mem[a] = merge(mem[a], s, d);
    sbs_conn_src_inst.q.push_back('{ob, ps, s, t, d});
  endtask

  task automatic drain();
    int n;
    for (n = 0; n < 300; n++) begin
      bus(1'b0, SBS_STAT_ADDR, 32'h0, 4'hF);
      if (rd[2:1] === 2'b00 && sbs_conn_src_inst.idle() && exp_q.size() == 0) break;
    end
    if (n == 300) expired();
  endtask

  task automatic set_mode(input logic [7:0] m);
    drain();
    bus(1'b1, SBS_MODE_ADDR, {24'h0, m}, 4'hF);
    mode = m;
  endtask

  task automatic tick();
    drain();
    @(posedge i_mclk);
    tick_s <= 1'b1;
    @(posedge i_mclk);
    tick_s <= 1'b0;
    if (mode[SBS_MODE_DBUF]) act = !act;
    bus(1'b0, SBS_STAT_ADDR, 32'h0, 4'hF);
    compare({31'h0, rd[SBS_STAT_PAGE]}, {31'h0, act});
  endtask

  task automatic init_tags();
    for (int t = 0; t < 4; t++) send(1'b0, 1'b0, rsub(0), 12'(t), 8'($urandom));
  endtask

  // Random mix of pieces, whole bytes and outbound reads on four locations
  task automatic rphase(input int n);
    int t;
    slow <= 1'($urandom_range(1));
    for (int i = 0; i < n; i++) begin
      t = $urandom_range(5);
      if (t == 5) send(1'b1, 1'($urandom), 7'($urandom), 12'($urandom_range(3)), 8'h0);
      else send(1'b0, 1'($urandom), rsub(t > 3 ? 3 : t),
                12'($urandom_range(3)), 8'($urandom));
    end
    drain();
  endtask

  initial begin
    {i_rstn, rd_s, wr_s, tick_s, slow, act, addr, wdata, be, mode, rd} = '0;
    {mismatches, comparisons, refusals} = '0;
    void'($urandom(32'h8425b7ce));
    repeat (16) @(posedge i_mclk);
    i_rstn <= 1'b1;
    // Reset value, unmapped place, disabled lane, read-only status
    bus(1'b0, SBS_MODE_ADDR, 32'h0, 4'hF);
    compare(rd, {24'h0, SBS_MODE_RST});
    bus(1'b1, SBS_MODE_ADDR, 32'h80, 4'h0);
    bus(1'b1, 12'h420, 32'hFF, 4'hF);
    bus(1'b0, 12'h420, 32'h0, 4'hF);
    compare(rd, 32'h0);
    bus(1'b1, SBS_STAT_ADDR, 32'hFF, 4'hF);
    bus(1'b0, SBS_MODE_ADDR, 32'h0, 4'hF);
    compare(rd, 32'h0);
    set_mode(8'h80);
    bus(1'b0, SBS_MODE_ADDR, 32'h0, 4'hF);
    compare(rd, 32'h80);
    $display("test registers done");
    // Rearrangement off: a bit entry stores the whole byte
    set_mode(8'h00);
    init_tags();
    send(1'b0, 1'b0, 7'h5A, 12'h0, 8'hA5);
    send(1'b1, 1'b0, 7'h7F, 12'h0, 8'h0);
    drain();
    $display("test subrate off done");
    // Every single-bit source and destination, then four di-bits packed
    set_mode(8'h80);
    init_tags();
    for (k = 0; k < 8; k++) send(1'b0, 1'b0, {1'b1, 3'(k), 3'(~k)}, 12'h1, 8'($urandom));
    send(1'b0, 1'b0, 7'b0100011, 12'h2, 8'($urandom));
    send(1'b0, 1'b0, 7'b0100101, 12'h2, 8'($urandom));
    send(1'b0, 1'b0, 7'b0101000, 12'h2, 8'($urandom));
    send(1'b0, 1'b0, 7'b0110110, 12'h2, 8'($urandom));
    send(1'b1, 1'b0, 7'h55, 12'h1, 8'h0);
    send(1'b1, 1'b0, 7'h2A, 12'h2, 8'h0);
    // One byte rebroadcast on four channels; each copy gives up one di-bit
    bcast = 8'($urandom);
    for (k = 0; k < 4; k++) begin
      send(1'b0, 1'b0, {2'b01, 2'(k), 1'b0, 2'(3 - k)}, 12'(k), bcast);
    end
    for (k = 0; k < 4; k++) send(1'b1, 1'b0, 7'($urandom), 12'(k), 8'h0);
    drain();
    $display("test bit and packing corners done");
    rphase(80);
    $display("test random single buffer done");
    // Ten back to back outbound entries; the buffer must refuse at least once
    slow <= 1'b0;
    refusals = 0;
    for (k = 0; k < 10; k++) send(1'b1, 1'b0, 7'($urandom), 12'h3, 8'h0);
    drain();
    compare({31'h0, refusals > 0}, 32'h1);
    $display("test buffer full done");
    // Two pages: page select bit picks the page of pieces and reads
    set_mode(8'h81);
    init_tags();
    tick();
    init_tags();
    tick();
    rphase(60);
    tick();
    rphase(30);
    $display("test double buffer done");
    print_verdict();
  end
endmodule
`default_nettype wire
